// ==== verilog/uart_chain.sv ====
// Serial channel: error-checked receiver, chained transmitter, transfer counter
// How it works
// R1: Three error flags plus a summary flag
// R2: Parity and framing flags refresh at receive done
// R3: Overrun holds until the buffer is read
// R4: Line activity alone never changes error flags
// R5: Overrun when new character meets unread buffer
// R6: Forced parity mismatch raises parity error
// R7: Odd/even count mismatch raises parity error
// R8: Missing stop bit raises framing error
// R9: All-zero frame sets break flag
// R10: Break flag refreshes at receive done
// R11: Buffered character follows with no gap
// R12: Software reloads between shift load and done
// R13: Transfer counter runs up to 255 characters
// R14: Inter-character gap stays within the bound
// R15: Clock master low stops all communication
// R16: Software picks the baud timer first
// R17: Baud timer runs from the oscillator
// R18: Seven-bit MSB first sends bp7 down to bp1
// R19: Seven-bit LSB first sends bp0 up to bp6
// R20: Seven-bit MSB first fills bp7 down to bp1
// R21: Seven-bit LSB first fills bp0 up to bp6
// R22: Software checks flags before next character
// R23: Parity field selects zero, one, odd, even; parity_off_in turns parity off
`timescale 1ns/10ps
`default_nettype none
module uart_chain
  import uart_chain_pkg::*;
#(
  parameter int DEPTH = FIFO_DEP
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       clock_master_in,
  input  wire logic [7:0] baud_div_in,
  input  wire logic       char8_in,
  input  wire logic       stop2_in,
  input  wire logic       parity_off_in,
  input  wire logic [1:0] parity_mode_in,
  input  wire logic       msb_first_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output var  logic       tx_ready_out,
  input  wire logic       atc_start_in,
  input  wire logic [7:0] atc_len_in,
  output var  logic       atc_busy_out,
  output var  logic       txd_out,
  output var  logic       tx_buffer_state_flag_out,
  output var  logic       tx_complete_irq_out,
  input  wire logic       rxd_in,
  input  wire logic       rx_read_in,
  output var  logic [7:0] rx_data_out,
  output var  logic       rx_full_out,
  output var  logic       rx_complete_irq_out,
  output var  logic       overrun_err_flag_out,
  output var  logic       parity_err_flag_out,
  output var  logic       framing_err_flag_out,
  output var  logic       any_rx_err_flag_out,
  output var  logic       break_seen_flag_out
);
  initial begin
    if (DEPTH < 2)
      $error("transmit fifo too shallow");
  end

  // ---------------------------------------------------------------
  // Baud tick
  // ---------------------------------------------------------------
  logic [7:0] div_reg;
  logic       tick;

  // Sixteen ticks per bit; no tick unless clock master
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= BYTE_RST;
      tick    <= 1'b0;
    end else if (!clock_master_in) begin // R15
      div_reg <= BYTE_RST;
      tick    <= 1'b0;
    end else if (div_reg >= baud_div_in) begin
      div_reg <= BYTE_RST;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      tick    <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------
  logic [7:0]  fifo_data;
  logic        fifo_valid;
  logic [7:0]  tx_buf_reg;
  logic [7:0]  tx_sh_reg;
  logic [2:0]  tx_bit_reg;
  logic [3:0]  tx_cnt_reg;
  logic        tx_stop_reg;
  logic        tx_par_reg;
  logic        tx_load;
  logic        tx_bit_end;
  logic        tx_last_stop;
  line_state_t tx_st_reg;
  logic [2:0]  last_bit;

  assign last_bit = char8_in ? BITS_LONG : BITS_SHRT;

  uart_chain_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) tx_fifo (
    .clk_in        (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (tx_data_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (!tx_buffer_state_flag_out)
  );

  assign tx_bit_end   = tick && (tx_cnt_reg == TICK_LAST);
  assign tx_last_stop = tx_bit_end && (tx_st_reg == ST_STOP) && (tx_stop_reg || !stop2_in);
  // Shift register takes the buffer when idle or right at frame end
  // A fresh frame needs clock master; a chained one rides the last stop tick
  assign tx_load = tx_buffer_state_flag_out &&
                   ((tx_st_reg == ST_IDLE && clock_master_in) || tx_last_stop); // R11 R15

  // Buffer between fifo and shift register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_buf_reg               <= BYTE_RST;
      tx_buffer_state_flag_out <= 1'b0;
    end else if (!tx_buffer_state_flag_out && fifo_valid) begin
      tx_buf_reg               <= fifo_data;
      tx_buffer_state_flag_out <= 1'b1; // R11
    end else if (tx_load) begin
      tx_buffer_state_flag_out <= 1'b0;
    end
  end

  // Transmit sequencer, one bit per sixteen ticks
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st_reg   <= ST_IDLE;
      tx_sh_reg   <= BYTE_RST;
      tx_bit_reg  <= '0;
      tx_cnt_reg  <= '0;
      tx_stop_reg <= 1'b0;
      tx_par_reg  <= 1'b0;
      txd_out     <= 1'b1;
    end else if (tx_load) begin
      tx_st_reg   <= ST_START;
      tx_sh_reg   <= char_mask(tx_buf_reg, msb_first_in, char8_in);
      tx_par_reg  <= par_bit(parity_mode_in,
                             char_mask(tx_buf_reg, msb_first_in, char8_in)); // R23
      tx_bit_reg  <= '0;
      tx_cnt_reg  <= '0;
      tx_stop_reg <= 1'b0;
      txd_out     <= 1'b0; // R11
    end else if (tick) begin
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
      if (tx_cnt_reg == TICK_LAST) begin
        case (tx_st_reg)
          ST_START: begin
            tx_st_reg <= ST_DATA;
            txd_out   <= msb_first_in ? tx_sh_reg[7] : tx_sh_reg[0]; // R18 R19
          end
          ST_DATA: begin
            tx_sh_reg  <= msb_first_in ? {tx_sh_reg[6:0], 1'b0} : {1'b0, tx_sh_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == last_bit) begin
              tx_st_reg <= parity_off_in ? ST_STOP : ST_PAR; // R23
              txd_out   <= parity_off_in ? 1'b1 : tx_par_reg;
            end else begin
              txd_out <= msb_first_in ? tx_sh_reg[6] : tx_sh_reg[1];
            end
          end
          ST_PAR: begin
            tx_st_reg <= ST_STOP;
            txd_out   <= 1'b1;
          end
          ST_STOP: begin
            if (tx_stop_reg || !stop2_in) begin
              tx_st_reg <= ST_IDLE;
            end
            tx_stop_reg <= 1'b1;
            txd_out     <= 1'b1;
          end
          default: begin
            tx_st_reg <= ST_IDLE;
            txd_out   <= 1'b1;
          end
        endcase
      end
    end else if (tx_st_reg == ST_IDLE) begin
      tx_cnt_reg <= '0;
    end
  end

  // Done pulse at the end of every last stop bit
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      tx_complete_irq_out <= 1'b0;
    else
      tx_complete_irq_out <= tx_last_stop;
  end

  // ---------------------------------------------------------------
  // Automatic transfer counter
  // ---------------------------------------------------------------
  logic [7:0] atc_left_reg;

  // Counts characters taken into the shift register; fifo keeps gap at zero
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      atc_left_reg <= BYTE_RST;
      atc_busy_out <= 1'b0;
    end else if (atc_start_in && !atc_busy_out) begin
      atc_left_reg <= atc_len_in; // R13
      atc_busy_out <= (atc_len_in != BYTE_RST);
    end else if (tx_load && atc_busy_out) begin
      atc_left_reg <= atc_left_reg - 8'h01; // R13 R14
      atc_busy_out <= (atc_left_reg != 8'h01);
    end
  end

  // ---------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------
  line_state_t rx_st_reg;
  logic [7:0]  rx_sh_reg;
  logic [7:0]  rx_char;
  logic [2:0]  rx_bit_reg;
  logic [3:0]  rx_cnt_reg;
  logic        rx_par_reg;
  logic        rx_zero_reg;
  logic        rx_mid;
  logic        rx_done;
  logic        ovr_next;
  logic        par_next;
  logic        frm_next;

  assign rx_mid  = tick && (rx_cnt_reg == TICK_LAST);
  assign rx_done = rx_mid && (rx_st_reg == ST_STOP);
  // Seven-bit characters land high for MSB first, low for LSB first
  assign rx_char = char8_in ? rx_sh_reg :
                   msb_first_in ? {rx_sh_reg[6:0], 1'b0} : {1'b0, rx_sh_reg[7:1]}; // R20 R21

  // Receive sequencer; start must stay low half a bit
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_reg   <= ST_IDLE;
      rx_sh_reg   <= BYTE_RST;
      rx_bit_reg  <= '0;
      rx_cnt_reg  <= '0;
      rx_par_reg  <= 1'b0;
      rx_zero_reg <= 1'b1;
    end else if (tick) begin
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
      case (rx_st_reg)
        ST_IDLE: begin
          rx_cnt_reg  <= '0;
          rx_zero_reg <= 1'b1;
          if (!rxd_in)
            rx_st_reg <= ST_START;
        end
        ST_START: begin
          if (rxd_in) begin
            rx_st_reg <= ST_IDLE;
          end else if (rx_cnt_reg == TICK_HALF) begin
            rx_st_reg  <= ST_DATA;
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
          end
        end
        ST_DATA: begin
          if (rx_cnt_reg == TICK_LAST) begin
            rx_sh_reg   <= msb_first_in ? {rx_sh_reg[6:0], rxd_in} : {rxd_in, rx_sh_reg[7:1]};
            rx_zero_reg <= rx_zero_reg && !rxd_in; // R9
            rx_bit_reg  <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == last_bit)
              rx_st_reg <= parity_off_in ? ST_STOP : ST_PAR;
          end
        end
        ST_PAR: begin
          if (rx_cnt_reg == TICK_LAST) begin
            rx_par_reg  <= rxd_in;
            rx_zero_reg <= rx_zero_reg && !rxd_in; // R9
            rx_st_reg   <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_cnt_reg == TICK_LAST)
            rx_st_reg <= ST_IDLE;
        end
        default: rx_st_reg <= ST_IDLE;
      endcase
    end
  end

  // Error sources at the stop bit sample
  assign par_next = !parity_off_in &&
                    (rx_par_reg != par_bit(parity_mode_in, rx_char)); // R6 R7
  assign frm_next = !rxd_in; // R8
  // The clearing read wins over the set
  assign ovr_next = rx_done ? ((overrun_err_flag_out || rx_full_out) && !rx_read_in) // R5
                  : (overrun_err_flag_out && !rx_read_in); // R3

  // Receive buffer and full indication
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_data_out <= BYTE_RST;
      rx_full_out <= 1'b0;
    end else if (rx_done) begin
      rx_data_out <= rx_char;
      rx_full_out <= 1'b1;
    end else if (rx_read_in) begin
      rx_full_out <= 1'b0;
    end
  end

  // Error and break flags move only on receive done or buffer read
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_complete_irq_out  <= 1'b0;
      overrun_err_flag_out <= 1'b0;
      parity_err_flag_out  <= 1'b0;
      framing_err_flag_out <= 1'b0;
      any_rx_err_flag_out  <= 1'b0;
      break_seen_flag_out  <= 1'b0;
    end else begin
      rx_complete_irq_out  <= rx_done;
      overrun_err_flag_out <= ovr_next; // R3 R4
      if (rx_done) begin
        parity_err_flag_out  <= par_next; // R2
        framing_err_flag_out <= frm_next; // R2
        break_seen_flag_out  <= rx_zero_reg && !rxd_in; // R9 R10
        any_rx_err_flag_out  <= ovr_next || par_next || frm_next; // R1
      end else begin
        any_rx_err_flag_out <= ovr_next || parity_err_flag_out || framing_err_flag_out; // R1
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_chained;
    $past(tx_buffer_state_flag_out) ##0 tx_complete_irq_out;
  endsequence

  property p_err_summary;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      any_rx_err_flag_out == (overrun_err_flag_out || parity_err_flag_out
                              || framing_err_flag_out);
  endproperty
  a_err_summary: assert property (p_err_summary) // R1
    else $error("summary flag disagrees with error flags");

  property p_pf_on_done;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ($changed(parity_err_flag_out) || $changed(framing_err_flag_out)) |->
        rx_complete_irq_out;
  endproperty
  a_pf_on_done: assert property (p_pf_on_done) // R2
    else $error("parity or framing flag moved without receive done");

  property p_ovr_hold;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $fell(overrun_err_flag_out) |-> $past(rx_read_in);
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) // R3
    else $error("overrun flag cleared without a read");

  property p_ovr_cause;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $changed(overrun_err_flag_out) |-> rx_complete_irq_out || $past(rx_read_in);
  endproperty
  a_ovr_cause: assert property (p_ovr_cause) // R4
    else $error("overrun flag moved without its event");

  property p_ovr_set;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      rx_complete_irq_out && $past(rx_full_out && !rx_read_in, 2) && !$past(rx_read_in)
        |-> overrun_err_flag_out;
  endproperty
  a_ovr_set: assert property (p_ovr_set) // R5
    else $error("unread buffer overwritten without overrun");

  property p_brk_on_done;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $changed(break_seen_flag_out) |-> rx_complete_irq_out;
  endproperty
  a_brk_on_done: assert property (p_brk_on_done) // R10
    else $error("break flag moved without receive done");

  property p_no_gap;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_chained |-> !txd_out ##1 !txd_out;
  endproperty
  a_no_gap: assert property (p_no_gap) // R11
    else $error("gap between chained characters");

  property p_master_off;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !clock_master_in [*3] |-> $stable(rx_st_reg) && $stable(tx_st_reg) && !tick;
  endproperty
  a_master_off: assert property (p_master_off) // R15
    else $error("channel active without clock master");
endmodule
`default_nettype wire

// ==== verilog/uart_chain_pkg.sv ====
// Shared constants, types and helpers of the serial channel
package uart_chain_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         CLK_HZ       = 250_000_000;
  localparam int         OVERSAMPLE   = 16;
  localparam logic [3:0] TICK_LAST    = 4'hf;
  localparam logic [3:0] TICK_HALF    = 4'h7;
  localparam logic [7:0] BAUD_DIV_RST = 8'h0f;
  // ---------------------------------------------------------------
  // Frame and parity encodings, transfer and fifo limits, reset byte
  // ---------------------------------------------------------------
  localparam logic [1:0] PAR_ZERO  = 2'h0;
  localparam logic [1:0] PAR_ONE   = 2'h1;
  localparam logic [1:0] PAR_ODD   = 2'h2;
  localparam logic [1:0] PAR_EVEN  = 2'h3;
  localparam logic [2:0] BITS_LONG = 3'h7;
  localparam logic [2:0] BITS_SHRT = 3'h6;
  localparam int         ATC_MAX   = 255;
  localparam int         FIFO_DEP  = 16;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6
  } line_state_t;

  // Keep only the character bits of a buffer byte
  function automatic logic [7:0] char_mask(input logic [7:0] d,
                                           input logic msb, input logic c8);
    if (c8)
      char_mask = d;
    else if (msb)
      char_mask = {d[7:1], 1'b0};
    else
      char_mask = {1'b0, d[6:0]};
  endfunction

  // Parity bit that a correct frame carries
  function automatic logic par_bit(input logic [1:0] mode, input logic [7:0] d);
    case (mode)
      PAR_ZERO: par_bit = 1'b0;
      PAR_ONE:  par_bit = 1'b1;
      PAR_ODD:  par_bit = ~(^d);
      default:  par_bit = ^d;
    endcase
  endfunction
endpackage

// ==== verilog/uart_chain_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module uart_chain_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output var  logic             in_ready_out,
  output var  logic [WIDTH-1:0] out_data_out,
  output var  logic             out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem[rd_reg];
  assign out_valid_out = (cnt_reg != '0);
  assign cnt_next      = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Storage write
  always_ff @(posedge clk_in) begin
    if (push)
      mem[wr_reg] <= in_data_in;
  end

  // Pointers, fill count and registered ready
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_reg       <= '0;
      rd_reg       <= '0;
      cnt_reg      <= '0;
      in_ready_out <= 1'b0;
    end else begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      cnt_reg      <= cnt_next;
      in_ready_out <= (cnt_next != DEPTH[AW:0]);
    end
  end
endmodule
`default_nettype wire

// ==== sim/uart_far_end.sv ====
// Remote serial transceiver model on the far side of the line
`timescale 1ns/10ps
`default_nettype none
module uart_far_end #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk_in,
  input  wire logic txd_in,
  output var  logic rxd_out
);
  // Line idles high
  initial begin
    rxd_out = 1'b1;
  end
  // ------------------------------------------
  // Line tasks
  // ------------------------------------------
  // Send n bits, bit 0 first, then one idle bit
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_out <= bits[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_in);
  endtask
  // Catch n bits from the next start bit, sampled mid-bit
  task automatic grab(output logic [11:0] bits, input int n);
    int k;
    bits = 12'h000;
    k = 0;
    while (txd_in !== 1'b0 && k < 4000) begin
      @(posedge clk_in);
      k++;
    end
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_in;
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/uart_chain_bench.sv ====
// Self-checking bench of the serial channel
`timescale 1ns/10ps
`default_nettype none
module uart_chain_bench;
  import uart_chain_pkg::*;
  localparam int DEPTH = FIFO_DEP;
  logic       clk;
  logic       rst_n;
  logic       cm, c8, s2, poff, msb, txv, atcs, rd, rxd;
  logic [1:0] pm;
  logic [7:0] txd8, alen, bdiv, rx_data;
  logic       tx_ready, busy, txd, tbf, tirq, rx_full, rirq;
  logic       ovr, perr, ferr, aerr, brk;
  int         err_total, num_checks, rxi_n, tirq_n, chain_n, bad_low;
  uart_chain i_dut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .clock_master_in(cm), .baud_div_in(bdiv),
    .char8_in(c8), .stop2_in(s2), .parity_off_in(poff), .parity_mode_in(pm),
    .msb_first_in(msb), .tx_data_in(txd8), .tx_valid_in(txv), .tx_ready_out(tx_ready),
    .atc_start_in(atcs), .atc_len_in(alen), .atc_busy_out(busy), .txd_out(txd),
    .tx_buffer_state_flag_out(tbf), .tx_complete_irq_out(tirq), .rxd_in(rxd),
    .rx_read_in(rd), .rx_data_out(rx_data), .rx_full_out(rx_full),
    .rx_complete_irq_out(rirq), .overrun_err_flag_out(ovr), .parity_err_flag_out(perr),
    .framing_err_flag_out(ferr), .any_rx_err_flag_out(aerr), .break_seen_flag_out(brk));
  uart_far_end i_far (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
  // Clock and event counters
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (rirq === 1'b1) rxi_n++;
    if (tirq === 1'b1) tirq_n++;
    if (tirq === 1'b1 && txd === 1'b0) chain_n++;
    if (cm === 1'b0 && txd === 1'b0) bad_low++;
  end
  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [11:0] frm(input logic [7:0] d, input int nb, input logic pb,
                                      input logic sb);
    logic [11:0] f;
    int j;
    f = 12'h000;
    j = 1;
    for (int i = 0; i < nb; i++) begin
      f[j] = msb ? d[7-i] : d[i];
      j++;
    end
    if (!poff) begin
      f[j] = pb;
      j++;
    end
    f[j] = sb;
    return f;
  endfunction
  // Correct parity bit for the current mode
  function automatic logic gp(input logic [7:0] d);
    logic [7:0] m;
    m = c8 ? d : (msb ? {d[7:1], 1'b0} : {1'b0, d[6:0]});
    case (pm)
      2'h0: return 1'b0;
      2'h1: return 1'b1;
      2'h2: return ~(^m);
      default: return ^m;
    endcase
  endfunction
  task automatic rx(input logic [7:0] d, input int nb, input logic pb, input logic sb);
    int n0;
    n0 = rxi_n;
    i_far.send(frm(d, nb, pb, sb), nb + (poff ? 2 : 3));
    chk("rx irq", 12'(rxi_n - n0), 12'h001);
  endtask
  task automatic rdb();
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] d);
    int k;
    k = 0;
    txd8 <= d;
    txv <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (tx_ready !== 1'b1 && k < 5000);
    txv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_tx(input int n);
    int k;
    k = 0;
    while (tirq_n < n && k < 60000) begin
      @(posedge clk);
      k++;
    end
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_modes();
    logic [7:0]  d;
    logic [11:0] got;
    for (int m = 0; m < 4; m++) begin
      pm <= 2'(m);
      @(posedge clk);
      d = 8'ha5 ^ 8'(m);
      rx(d, 8, ~gp(d), 1'b1);
      chk("perr bad", perr, 1'b1);
      chk("aerr bad", aerr, 1'b1);
      chk("data", rx_data, d);
      rdb();
      rx(d, 8, gp(d), 1'b1);
      chk("perr good", perr, 1'b0);
      chk("ferr good", ferr, 1'b0);
      chk("aerr good", aerr, 1'b0);
      rdb();
    end
    // No parity bit on either direction
    poff <= 1'b1;
    @(posedge clk);
    rx(8'hc3, 8, 1'b0, 1'b1);
    chk("perr off", perr, 1'b0);
    chk("data off", rx_data, 8'hc3);
    rdb();
    fork
      i_far.grab(got, 10);
      wr(8'h96);
    join
    chk("tx off", got, frm(8'h96, 8, 1'b0, 1'b1));
    repeat (20) @(posedge clk);
    poff <= 1'b0;
    @(posedge clk);
    $display("parity modes done");
  endtask
  task automatic t_frame_break();
    pm <= 2'h0;
    @(posedge clk);
    rx(8'h3c, 8, 1'b0, 1'b0);
    chk("ferr", ferr, 1'b1);
    chk("brk part", brk, 1'b0);
    chk("aerr", aerr, 1'b1);
    rdb();
    rx(8'h00, 8, 1'b0, 1'b0);
    chk("brk", brk, 1'b1);
    rdb();
    rx(8'h81, 8, 1'b0, 1'b1);
    chk("brk off", brk, 1'b0);
    chk("ferr off", ferr, 1'b0);
    rdb();
    $display("framing and break done");
  endtask
  task automatic t_overrun();
    rx(8'h11, 8, 1'b0, 1'b1);
    chk("ovr first", ovr, 1'b0);
    rx(8'h22, 8, 1'b0, 1'b1);
    chk("ovr", ovr, 1'b1);
    chk("data new", rx_data, 8'h22);
    repeat (60) @(posedge clk);
    chk("ovr hold", ovr, 1'b1);
    chk("aerr ovr", aerr, 1'b1);
    rdb();
    chk("ovr clr", ovr, 1'b0);
    chk("aerr clr", aerr, 1'b0);
    chk("full clr", rx_full, 1'b0);
    $display("overrun done");
  endtask
  task automatic t_seven();
    logic [11:0] got;
    c8 <= 1'b0;
    pm <= 2'h3;
    for (int m = 0; m < 2; m++) begin
      msb <= m[0];
      @(posedge clk);
      rx(8'h5b, 7, gp(8'h5b), 1'b1);
      chk("rx7", rx_data, msb ? 8'h5a : 8'h5b);
      rdb();
      fork
        i_far.grab(got, 10);
        wr(8'h6d);
      join
      chk("tx7", got, frm(8'h6d, 7, gp(8'h6d), 1'b1));
      repeat (20) @(posedge clk);
    end
    c8 <= 1'b1;
    msb <= 1'b0;
    @(posedge clk);
    $display("seven bit done");
  endtask
  task automatic t_fill();
    int acc, n0, c0;
    acc = 0;
    n0 = tirq_n;
    c0 = chain_n;
    cm <= 1'b0;
    s2 <= 1'b1;
    txv <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      txd8 <= 8'h40 + 8'(i);
      @(posedge clk);
      if (tx_ready === 1'b1) acc++;
    end
    txv <= 1'b0;
    repeat (100) @(posedge clk);
    chk("accepted", 12'(acc), 12'(DEPTH + 1));
    chk("buf flag", tbf, 1'b1);
    chk("no start", 12'(bad_low), 12'h000);
    cm <= 1'b1;
    wait_tx(n0 + acc);
    chk("drained", 12'(tirq_n - n0), 12'(acc));
    chk("no gap", 12'(chain_n - c0), 12'(acc - 1));
    s2 <= 1'b0;
    $display("fill and chain done");
  endtask
  task automatic t_atc();
    int n0, c0;
    n0 = tirq_n;
    c0 = chain_n;
    alen <= 8'hff;
    atcs <= 1'b1;
    @(posedge clk);
    atcs <= 1'b0;
    repeat (2) @(posedge clk);
    chk("busy", busy, 1'b1);
    for (int i = 0; i < 255; i++) begin
      wr(8'(i));
    end
    wait_tx(n0 + 255);
    repeat (4) @(posedge clk);
    chk("busy end", busy, 1'b0);
    chk("atc gap", 12'(chain_n - c0), 12'd254);
    $display("auto transfer done");
  endtask
  // ------------------------------------------
  // Verdict, watchdog and main sequence
  // ------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    close_out();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cm = 1'b1;
    bdiv = 8'h00;
    c8 = 1'b1;
    s2 = 1'b0;
    poff = 1'b0;
    pm = 2'h0;
    msb = 1'b0;
    txv = 1'b0;
    txd8 = 8'h00;
    atcs = 1'b0;
    alen = 8'h00;
    rd = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_modes();
    t_frame_break();
    t_overrun();
    t_seven();
    t_fill();
    t_atc();
    close_out();
  end
endmodule
`default_nettype wire
